// ### logic/sar_adc_defs.svh
/*
  Constants for the converter control logic: pin slots, field positions,
  reset values and bit-step timing counts.
  Assumes a single system clock whose rate is given here in MHz.
*/
`ifndef SAR_ADC_DEFS_SVH
`define SAR_ADC_DEFS_SVH

// ----------------------------------------------------------------------
// Clock and bit-step timing
// ----------------------------------------------------------------------
`define CLK_MHZ 25
// Nominal interval between trial codes, in ns
`define STEP_NS 950
// Comparator decision point after a code change, in ns
`define DECIDE_NS 850
// Nominal figures: both round down to whole cycles (23 and 21)
`define STEP_CYCLES ((`STEP_NS * `CLK_MHZ) / 1000)
`define DECIDE_CYCLES ((`DECIDE_NS * `CLK_MHZ) / 1000)
`define CNT_W 5

// ----------------------------------------------------------------------
// Result layout
// ----------------------------------------------------------------------
`define RES_BITS 12
`define IDX_W 4
`define FULL_LAST_BIT 4'h0
`define SHORT_LAST_BIT 4'h4
`define MSB_IDX 4'hB
`define TRIAL_FIRST 12'h800
`define SHORT_TAIL 4'h8
`define RESULT_RESET 12'h000

// ----------------------------------------------------------------------
// Output enable patterns
// ----------------------------------------------------------------------
`define OE_ALL 12'hFFF
`define OE_HIGH_BYTE 12'hFF0
`define OE_LOW_BYTE 12'h0FF
`define OE_NONE 12'h000

// ----------------------------------------------------------------------
// Slots of the synchronised pin vector
// ----------------------------------------------------------------------
`define PIN_CE 0
`define PIN_CS_N 1
`define PIN_RC 2
`define PIN_WIDTH 3
`define PIN_BYTE_SEL 4
`define PIN_CMP 5
`define PIN_COUNT 6

`endif

// ### logic/sar_adc_pkg.sv
/*
  Types shared by the converter control logic and its bit-step engine.
  Assumes sar_adc_defs.svh is on the include path.
*/
`default_nettype none
`include "sar_adc_defs.svh"

package sar_adc_pkg;

  // ----------------------------------------------------------------------
  // Bit-step engine state
  // ----------------------------------------------------------------------
  typedef enum logic {
    ENG_IDLE,
    ENG_RUN
  } eng_phase_t;

  typedef struct packed {
    eng_phase_t phase;                            // Idle or converting
    logic [`CNT_W-1:0] cnt;                       // Cycle within bit step
    logic [`IDX_W-1:0] idx;                       // Bit under trial
    logic [`RES_BITS-1:0] successive_approx_register; // Trial code
    logic done;                                   // One-cycle end pulse
  } eng_state_t;

  // ----------------------------------------------------------------------
  // Control front end state
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic [`PIN_COUNT-1:0] s1;                    // Synchroniser stage 1
    logic [`PIN_COUNT-1:0] s2;                    // Synchroniser stage 2
    logic [`PIN_COUNT-1:0] s3;                    // Synchroniser stage 3
    logic [`PIN_COUNT-1:0] filt;                  // Agreed pin levels
    logic qual_prev;                              // Start qualifier, last cycle
    logic byte_select_short_cycle;                // Latched at each start
    logic [`RES_BITS-1:0] result;                 // Last finished result
    logic [`RES_BITS-1:0] data;                   // Data pin values
    logic [`RES_BITS-1:0] oe;                     // Data pin enables
  } ctrl_state_t;

endpackage

`default_nettype wire

// ### logic/sar_step_if.sv
/*
  Carrier between the control front end and the bit-step engine.
  Assumes both sides run on the same system clock.
*/
`timescale 1ns/1ps
`default_nettype none

interface sar_step_if;
  logic start;                      // One-cycle accepted start
  logic short_cycle;                // High stops after 8 bits
  logic comp;                       // Synchronised comparator: keep bit
  logic [11:0] code;                // Current trial / final code
  logic busy;                       // Conversion in progress
  logic done;                       // One-cycle completion pulse

  modport ctrl (output start, output short_cycle, output comp,
                input code, input busy, input done);
  modport engine (input start, input short_cycle, input comp,
                  output code, output busy, output done);
endinterface

`default_nettype wire

// ### logic/sar_step_engine.sv
/*
  Successive-approximation engine: walks the trial code from the MSB
  down, one bit per fixed step, keeping or dropping each bit on the
  comparator's word.
  Assumes start only arrives while idle and comp is already synchronised.
*/
`timescale 1ns/1ps
`default_nettype none
`include "sar_adc_defs.svh"

module sar_step_engine (
  input wire logic clk,
  input wire logic rst_n,
  sar_step_if.engine step
);

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  sar_adc_pkg::eng_state_t q; // Registered state
  sar_adc_pkg::eng_state_t d; // Next state
  logic last_bit;             // Current step ends the conversion

  // Length is read live so a re-latched short-cycle level takes effect
  assign last_bit = (q.idx == `FULL_LAST_BIT) ||
                    (step.short_cycle && (q.idx <= `SHORT_LAST_BIT));

  // Next-state logic
  always_comb begin
    d = q;
    d.done = 1'b0;
    case (q.phase)
      sar_adc_pkg::ENG_IDLE: begin
        if (step.start) begin
          d.phase = sar_adc_pkg::ENG_RUN;
          d.cnt = '0;
          d.idx = `MSB_IDX;
          d.successive_approx_register = `TRIAL_FIRST;
        end
      end
      sar_adc_pkg::ENG_RUN: begin
        d.cnt = `CNT_W'(q.cnt + 1'b1);
        // Decision point inside the step
        if (q.cnt == `CNT_W'(`DECIDE_CYCLES - 1) && !step.comp) begin
          d.successive_approx_register[q.idx] = 1'b0;
        end
        // Step boundary: next trial bit or finish
        if (q.cnt == `CNT_W'(`STEP_CYCLES - 1)) begin
          d.cnt = '0;
          if (last_bit) begin
            d.phase = sar_adc_pkg::ENG_IDLE;
            d.done = 1'b1;
            if (step.short_cycle) begin
              d.successive_approx_register[3:0] = `SHORT_TAIL;
            end
          end else begin
            d.idx = `IDX_W'(q.idx - 1'b1);
            d.successive_approx_register[`IDX_W'(q.idx - 1'b1)] = 1'b1;
          end
        end
      end
      default: begin
        d.phase = sar_adc_pkg::ENG_IDLE;
      end
    endcase
  end

  // Register the whole state
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= '{phase: sar_adc_pkg::ENG_IDLE, cnt: '0, idx: '0,
             successive_approx_register: `RESULT_RESET, done: 1'b0};
    end else begin
      q <= d;
    end
  end

  assign step.code = q.successive_approx_register;
  assign step.busy = (q.phase == sar_adc_pkg::ENG_RUN);
  assign step.done = q.done;

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  a_new_bit_timing: assert property (@(posedge clk) disable iff (!rst_n)
    (step.busy && $past(step.busy) && ((q.successive_approx_register & ~$past(q.successive_approx_register)) != 0))
    |-> (q.cnt == 0) && ($past(q.cnt) == `CNT_W'(`STEP_CYCLES - 1)))
    else $error("Trial bit set off the step boundary");

  a_decide_timing: assert property (@(posedge clk) disable iff (!rst_n)
    (step.busy && $past(step.busy) && ((~q.successive_approx_register & $past(q.successive_approx_register)) != 0))
    |-> $past(q.cnt) == `CNT_W'(`DECIDE_CYCLES - 1))
    else $error("Bit dropped outside the decision point");

  a_full_length: assert property (@(posedge clk) disable iff (!rst_n)
    (q.done && !step.short_cycle) |-> $past(q.idx) == `FULL_LAST_BIT)
    else $error("Full conversion ended early");

endmodule

`default_nettype wire

// ### logic/sar_adc_control_logic.sv
/*
  Control logic of a 12-bit successive-approximation converter with a
  parallel processor interface: pin synchronisers, start detection,
  conversion status and the tri-state data output stage.
  Assumes all control pins and the comparator are asynchronous to
  CLK_SYS_IN, and that data pins are resolved outside from the enables.
*/
`timescale 1ns/1ps
`default_nettype none
`include "sar_adc_defs.svh"

module sar_adc_control_logic (
  input wire logic CLK_SYS_IN,
  input wire logic RESETN_IN,
  input wire logic CHIP_ENABLE_IN,
  input wire logic CHIP_SELECT_N_IN,
  input wire logic READ_CONVERT_IN,
  input wire logic WIDTH_SELECT_IN,
  input wire logic BYTE_SELECT_SHORT_CYCLE_IN,
  input wire logic COMPARATOR_IN,
  output logic STATUS_OUT,
  output logic [11:0] TRIAL_CODE_OUT,
  output logic [11:0] DATA_OUT,
  output logic [11:0] DATA_OE_OUT
);

  // ----------------------------------------------------------------------
  // State and wiring
  // ----------------------------------------------------------------------
  sar_adc_pkg::ctrl_state_t q; // Registered state
  sar_adc_pkg::ctrl_state_t d; // Next state
  sar_step_if step ();         // Link to the bit-step engine
  logic [`PIN_COUNT-1:0] pins; // Raw pin vector
  logic [`PIN_COUNT-1:0] agree; // Stages 2 and 3 agree
  logic qual;                  // All three start inputs in convert state
  logic start_edge;            // Last of the three just arrived
  logic read_ok;               // Five read conditions met, including no start this cycle

  // ----------------------------------------------------------------------
  // Pin sampling and start detection
  // ----------------------------------------------------------------------
  // Comparator rides in the same synchroniser as the control pins, so
  // its word is three to four cycles old at the decision point
  assign pins = {COMPARATOR_IN, BYTE_SELECT_SHORT_CYCLE_IN, WIDTH_SELECT_IN,
                 READ_CONVERT_IN, CHIP_SELECT_N_IN, CHIP_ENABLE_IN};
  // Only stages 2 and 3 are compared; stage 1 may be metastable
  assign agree = ~(q.s2 ^ q.s3);

  // Start qualifier: whichever input reaches its state last fires
  assign qual = q.filt[`PIN_CE] && !q.filt[`PIN_CS_N] && !q.filt[`PIN_RC];
  assign start_edge = qual && !q.qual_prev;
  // Busy converter swallows the start itself
  assign step.start = start_edge && !step.busy;
  assign step.short_cycle = q.byte_select_short_cycle;
  assign step.comp = q.filt[`PIN_CMP];

  // ----------------------------------------------------------------------
  // Read gating
  // ----------------------------------------------------------------------
  // Reads need read mode, idle, enabled, selected; a start in this
  // cycle also blocks so enables never overlap a rising status
  assign read_ok = q.filt[`PIN_RC] && !step.busy && !step.start &&
                   q.filt[`PIN_CE] && !q.filt[`PIN_CS_N];

  // ----------------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------------
  always_comb begin
    d = q;
    // Three-stage synchroniser; a level counts once 2 and 3 agree
    d.s1 = pins;
    d.s2 = q.s1;
    d.s3 = q.s2;
    d.filt = (q.s2 & agree) | (q.filt & ~agree);
    d.qual_prev = qual;
    // Every start edge re-latches, even mid-conversion
    if (start_edge) begin
      d.byte_select_short_cycle = q.filt[`PIN_BYTE_SEL];
    end
    // Capture the finished code
    if (step.done) begin
      d.result = step.code;
    end
    // Output stage
    d.oe = `OE_NONE;
    d.data = '0;
    if (read_ok) begin
      if (q.filt[`PIN_WIDTH]) begin
        // Whole word at once, byte select ignored
        d.oe = `OE_ALL;
        d.data = d.result;
      end else if (!q.filt[`PIN_BYTE_SEL]) begin
        // Upper eight bits on the top lines
        d.oe = `OE_HIGH_BYTE;
        d.data = {d.result[11:4], 4'h0};
      end else begin
        // Low nibble on the bottom lines, next four forced zero
        d.oe = `OE_LOW_BYTE;
        d.data = {8'h00, d.result[3:0]};
      end
    end
  end

  // ----------------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------------
  always_ff @(posedge CLK_SYS_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      q <= '{s1: '0, s2: '0, s3: '0, filt: '0, qual_prev: 1'b0,
             byte_select_short_cycle: 1'b0, result: `RESULT_RESET,
             data: '0, oe: `OE_NONE};
    end else begin
      q <= d;
    end
  end

  // ----------------------------------------------------------------------
  // Bit-step engine
  // ----------------------------------------------------------------------
  sar_step_engine u_engine (
    .clk(CLK_SYS_IN),
    .rst_n(RESETN_IN),
    .step(step)
  );

  // Status straight from the engine's state flop
  assign STATUS_OUT = step.busy;
  assign TRIAL_CODE_OUT = step.code;
  assign DATA_OUT = q.data;
  assign DATA_OE_OUT = q.oe;

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  a_float_while_busy: assert property (@(posedge CLK_SYS_IN) disable iff (!RESETN_IN)
    STATUS_OUT |-> DATA_OE_OUT == `OE_NONE)
    else $error("Data driven during conversion");

  a_start_raises_status: assert property (@(posedge CLK_SYS_IN) disable iff (!RESETN_IN)
    (start_edge && !STATUS_OUT) |=> STATUS_OUT && TRIAL_CODE_OUT == `TRIAL_FIRST)
    else $error("Start did not begin a conversion");

  a_busy_no_restart: assert property (@(posedge CLK_SYS_IN) disable iff (!RESETN_IN)
    (start_edge && STATUS_OUT) |=>
      (u_engine.q.idx == $past(u_engine.q.idx) || $past(u_engine.q.cnt) == `CNT_W'(`STEP_CYCLES - 1)) &&
      (u_engine.q.cnt == (($past(u_engine.q.cnt) == `CNT_W'(`STEP_CYCLES - 1)) ? `CNT_W'(0) :
                          `CNT_W'($past(u_engine.q.cnt) + 1'b1))))
    else $error("Start while busy disturbed the conversion");

  a_select_relatch: assert property (@(posedge CLK_SYS_IN) disable iff (!RESETN_IN)
    start_edge |=> q.byte_select_short_cycle == $past(q.filt[`PIN_BYTE_SEL]))
    else $error("Byte select not latched at start");

  a_short_tail: assert property (@(posedge CLK_SYS_IN) disable iff (!RESETN_IN)
    (step.done && q.byte_select_short_cycle) |=> q.result[3:0] == `SHORT_TAIL)
    else $error("Short result tail wrong");

  a_read_gating: assert property (@(posedge CLK_SYS_IN) disable iff (!RESETN_IN)
    (DATA_OE_OUT != `OE_NONE) |-> $past(read_ok))
    else $error("Outputs enabled without read conditions");

  a_nibble_zeros: assert property (@(posedge CLK_SYS_IN) disable iff (!RESETN_IN)
    (DATA_OE_OUT == `OE_LOW_BYTE) |-> DATA_OUT[7:4] == 4'h0 && DATA_OUT[3:0] == q.result[3:0])
    else $error("Low byte not nibble plus zeros");

  a_standalone_start: assert property (@(posedge CLK_SYS_IN) disable iff (!RESETN_IN)
    ($fell(q.filt[`PIN_RC]) && q.filt[`PIN_CE] && $past(q.filt[`PIN_CE]) && !q.filt[`PIN_CS_N] &&
     !$past(q.filt[`PIN_CS_N]) && !STATUS_OUT) |=> STATUS_OUT)
    else $error("Read/convert fall did not start");

  // Whole-word and upper-byte patterns carry the stored result
  a_word_read: assert property (@(posedge CLK_SYS_IN) disable iff (!RESETN_IN)
    (DATA_OE_OUT == `OE_ALL) |-> DATA_OUT == q.result)
    else $error("Word read does not carry the result");

  a_high_byte: assert property (@(posedge CLK_SYS_IN) disable iff (!RESETN_IN)
    (DATA_OE_OUT == `OE_HIGH_BYTE) |-> DATA_OUT == {q.result[11:4], 4'h0})
    else $error("Upper byte read wrong");

  // Losing enable or select must float the lines on the next edge
  a_deselect_float: assert property (@(posedge CLK_SYS_IN) disable iff (!RESETN_IN)
    (!q.filt[`PIN_CE] || q.filt[`PIN_CS_N]) |=> DATA_OE_OUT == `OE_NONE)
    else $error("Lines driven while deselected");

  // Status falls only at the end of a last bit step; a late re-latch
  // to short may end below bit 4, which is accepted behaviour
  a_status_end: assert property (@(posedge CLK_SYS_IN) disable iff (!RESETN_IN)
    $fell(STATUS_OUT) |-> $past(u_engine.q.cnt) == `CNT_W'(`STEP_CYCLES - 1) &&
      ($past(u_engine.q.idx) == `FULL_LAST_BIT ||
       ($past(q.byte_select_short_cycle) && $past(u_engine.q.idx) <= `SHORT_LAST_BIT)))
    else $error("Status fell before the last bit step");

  // Finished code is stored on the edge after status falls
  a_result_capture: assert property (@(posedge CLK_SYS_IN) disable iff (!RESETN_IN)
    $fell(STATUS_OUT) |=> q.result == $past(TRIAL_CODE_OUT))
    else $error("Finished code not stored");

  // ----------------------------------------------------------------------
  // Coverage of the main scenarios
  // ----------------------------------------------------------------------
  c_word_read: cover property (@(posedge CLK_SYS_IN) disable iff (!RESETN_IN)
    DATA_OE_OUT == `OE_ALL);
  c_full_done: cover property (@(posedge CLK_SYS_IN) disable iff (!RESETN_IN)
    step.done && !q.byte_select_short_cycle);
  c_short_done: cover property (@(posedge CLK_SYS_IN) disable iff (!RESETN_IN)
    step.done && q.byte_select_short_cycle);
  c_start_while_busy: cover property (@(posedge CLK_SYS_IN) disable iff (!RESETN_IN)
    start_edge && STATUS_OUT);
  c_low_byte_read: cover property (@(posedge CLK_SYS_IN) disable iff (!RESETN_IN)
    DATA_OE_OUT == `OE_LOW_BYTE);

endmodule

`default_nettype wire

// ### verification/analog_front_model.sv
/*
  Behavioural analog front end: a held input level and an ideal
  comparator against the trial code from the converter.
  Assumes the level only changes while no conversion runs.
*/
`timescale 1ns/1ps
`default_nettype none

module analog_front_model (
  input wire logic [11:0] trial_in,
  input wire logic [11:0] level_in,
  output logic cmp_out
);
  // ----------------------------------------------------------------------
  // Comparator
  // ----------------------------------------------------------------------
  // Ideal and instant; it is settled long before the decision point
  assign cmp_out = (level_in >= trial_in);
endmodule

`default_nettype wire

// ### verification/tb_top.sv
/*
  Self-checking bench for the converter control logic: start by each
  start input (CE, CS_N, read/convert), full and short lengths, restart while busy, all read modes.
  Assumes the analog front end model closes the comparator loop.
*/
`timescale 1ns/1ps
`default_nettype none

module tb_top;
  // ----------------------------------------------------------------------
  // Stimulus and observed signals
  // ----------------------------------------------------------------------
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic ce = 1'b0;
  logic cs_n = 1'b0;
  logic rc = 1'b1; // Idle in read state so release starts nothing
  logic wid = 1'b1;
  logic byte_sel = 1'b0;
  logic [11:0] level = 12'h000;
  logic cmp;
  logic sts;
  logic [11:0] trial;
  logic [11:0] dout;
  logic [11:0] doe;
  logic [15:0] rnd = 16'h002d; // Random source seed
  int n_mismatch = 0;
  int n_tests = 0;
  int cycles = 0;
  logic [11:0] exp_q [$]; // Predicted results, oldest first

  // ----------------------------------------------------------------------
  // Instances
  // ----------------------------------------------------------------------
  analog_front_model u_afe (.trial_in(trial), .level_in(level), .cmp_out(cmp));
  sar_adc_control_logic u_dut (
    .CLK_SYS_IN(clk),
    .RESETN_IN(rst_n),
    .CHIP_ENABLE_IN(ce),
    .CHIP_SELECT_N_IN(cs_n),
    .READ_CONVERT_IN(rc),
    .WIDTH_SELECT_IN(wid),
    .BYTE_SELECT_SHORT_CYCLE_IN(byte_sel),
    .COMPARATOR_IN(cmp),
    .STATUS_OUT(sts),
    .TRIAL_CODE_OUT(trial),
    .DATA_OUT(dout),
    .DATA_OE_OUT(doe)
  );

  // Clock, 40 ns period
  always #20 clk = ~clk;

  // Hang guard: the whole run needs well under this many cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      n_mismatch++;
      final_report();
    end
  end

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  // Galois-free shift register, taps 16,14,13,11
  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  // Reference: ideal successive approximation; a short run ends in 1000
  function automatic logic [11:0] model_code(input int lv, input int nbits);
    int code;
    code = 0;
    for (int b = 11; b > 11 - nbits; b--) begin
      code = code | (1 << b);
      if (lv < code)
        code = code & ~(1 << b);
    end
    if (nbits == 8)
      code = code | 8;
    return code[11:0];
  endfunction

  // Single comparison point
  task automatic check(input logic [11:0] seen, input logic [11:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // One pin update per rising edge, never two in one step
  task automatic pins(input logic c, input logic s, input logic r, input logic w, input logic a);
    @(posedge clk);
    ce <= c;
    cs_n <= s;
    rc <= r;
    wid <= w;
    byte_sel <= a;
  endtask

  task automatic final_report();
    $display("mismatches %0d tests %0d", n_mismatch, n_tests);
    if (n_mismatch == 0 && n_tests > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // ----------------------------------------------------------------------
  // One conversion and its readback
  // ----------------------------------------------------------------------
  // Method 0: read/convert falls, 1: chip enable rises, 2: select falls
  task automatic convert(input int method, input logic short_c, input logic kick);
    int len;
    int wt;
    logic [11:0] lv;
    logic [11:0] e;
    logic [11:0] oe_tab [5];
    logic [11:0] dm_tab [5];
    oe_tab = '{12'hfff, 12'hfff, 12'hff0, 12'h0ff, 12'h000};
    dm_tab = '{12'hfff, 12'hfff, 12'hff0, 12'h00f, 12'h000};
    rnd = lfsr_next(rnd);
    lv = rnd[11:0];
    // A restart mid-run re-latches byte select high, so that run ends short
    exp_q.push_back(model_code(lv, (short_c || kick) ? 8 : 12));
    @(posedge clk) level <= lv;
    case (method)
      0: pins(1'b1, 1'b0, 1'b1, 1'b1, short_c);
      1: pins(1'b0, 1'b0, 1'b0, 1'b1, short_c);
      default: pins(1'b1, 1'b1, 1'b0, 1'b1, short_c);
    endcase
    repeat (6) @(posedge clk);
    check({11'h000, sts}, 12'h000);
    pins(1'b1, 1'b0, 1'b0, 1'b1, short_c);
    wt = 0;
    while (sts !== 1'b1 && wt < 10) begin
      @(negedge clk);
      wt++;
    end
    check(trial, 12'h800);
    len = 0;
    while (sts === 1'b1 && len < 400) begin
      @(negedge clk);
      len++;
      // Restart attempt mid-run: read/convert pulses high, byte select flips
      if (kick && len == 40)
        pins(1'b1, 1'b0, 1'b1, 1'b1, 1'b1);
      if (kick && len == 45)
        check(doe, 12'h000);
      if (kick && len == 48)
        pins(1'b1, 1'b0, 1'b0, 1'b1, 1'b1);
    end
    // Final trial code stays on the pins once status is low
    e = exp_q.pop_front();
    check(trial, e);
    wt = (short_c || kick) ? 8 * 23 : 12 * 23;
    check(len[11:0], wt[11:0]);
    // Word twice (byte select ignored), upper byte, low nibble, chip disabled
    for (int k = 0; k < 5; k++) begin
      pins(k != 4, 1'b0, 1'b1, k < 2, k == 1 || k == 3);
      repeat (5) @(posedge clk);
      @(negedge clk);
      check(doe, oe_tab[k]);
      check(dout, e & dm_tab[k]);
    end
  endtask

  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial begin
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    @(negedge clk);
    check({11'h000, sts}, 12'h000);
    check(doe, 12'h000);
    for (int i = 0; i < 10; i++) begin
      rnd = lfsr_next(rnd);
      convert(i % 3, rnd[15], i == 4);
    end
    final_report();
  end
endmodule

`default_nettype wire
